/* File: verilog/msac_pkg.sv */
// Purpose: Shared constants for the monitor sample and alarm compare block
// Assumes: 4.9152 MHz system clock
// Notes:   Timing counts derived from clock rate
package msac_pkg;
	localparam int unsigned SYS_CLK_HZ     = 4915200;
	localparam int unsigned SAMPLE_HZ      = 640;
	localparam int unsigned NUM_SLOTS      = 32;
	localparam int unsigned SLOT_DIV       = SYS_CLK_HZ / (SAMPLE_HZ * NUM_SLOTS);
	localparam int unsigned CONV_PULSE_LEN = 2;
	localparam int unsigned DATA_W         = 12;
	localparam int unsigned ADDR_W         = 5;
	localparam int unsigned ENTRY_W        = ADDR_W + DATA_W;
	localparam int unsigned SFIFO_DEPTH    = 7;
	localparam int unsigned NUM_PARAMS     = 32;
	localparam int unsigned EE_DATA_W      = 18;
	localparam int unsigned EE_ADDR_W      = 8;
	localparam logic [4:0]  CH_DIFF_FREQ   = 5'h00;
	localparam logic [4:0]  CH_ADC_BASE    = 5'h01;
	localparam logic [4:0]  CH_EXT_BASE    = 5'h11;
	localparam logic [4:0]  CH_LOOP        = 5'h19;
	localparam logic [4:0]  CH_EXT_VAL     = 5'h1a;
	localparam logic [4:0]  CH_TEST        = 5'h1b;
	localparam logic [4:0]  CH_LAST        = 5'h1b;
	localparam logic [1:0]  EE_SEL_UPPER   = 2'h0;
	localparam logic [1:0]  EE_SEL_LOWER   = 2'h1;
	localparam logic [1:0]  EE_SEL_DELAY   = 2'h2;
	localparam logic [1:0]  EE_SEL_WARN    = 2'h3;
	typedef enum logic [2:0] {
		MSAC_IDLE  = 3'b000,
		MSAC_UPPER = 3'b001,
		MSAC_LOWER = 3'b010,
		MSAC_DELAY = 3'b011,
		MSAC_EMIT  = 3'b100
	} msac_seq_t;
endpackage

/* File: verilog/msac_sample_fifo.sv */
// Purpose: Small sample queue between front end and processor
// Assumes: Writer does not stall; overflow drops data
// Notes:   Error flag sticky until cleared
`timescale 1ns/1ns
module msac_sample_fifo #(
	parameter int unsigned WIDTH = 17,
	parameter int unsigned DEPTH = 7
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	// Write side
	input  wire logic             wr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// Read side
	input  wire logic             rd_i,
	output logic      [WIDTH-1:0] rdata_o,
	output logic                  avail_o,
	// Error
	input  wire logic             err_clr_i,
	output logic                  err_o
);
	localparam int unsigned PW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    rp_q, rp_d, wp_q, wp_d, cnt_q, cnt_d;
	logic             err_q, err_d, do_wr, do_rd;

	always_comb begin
		do_rd = rd_i && (cnt_q != '0);
		do_wr = wr_i && (cnt_q != PW'(DEPTH) || do_rd);
		rp_d  = rp_q;
		wp_d  = wp_q;
		if (do_rd) begin
			rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
		end
		if (do_wr) begin
			wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
		end
		cnt_d = cnt_q + PW'(do_wr) - PW'(do_rd);
		err_d = (err_q && !err_clr_i) || (wr_i && !do_wr);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rp_q  <= '0;
			wp_q  <= '0;
			cnt_q <= '0;
			err_q <= 1'b0;
		end else begin
			rp_q  <= rp_d;
			wp_q  <= wp_d;
			cnt_q <= cnt_d;
			err_q <= err_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem_q[wp_q] <= wdata_i;
		end
	end

	assign rdata_o = mem_q[rp_q];
	assign avail_o = (cnt_q != '0);
	assign err_o   = err_q;
endmodule

/* File: verilog/msac_parity.sv */
// Purpose: Hamming SEC-DED decode of an 18-bit EEPROM word to 12 data bits
// Assumes: Word layout [17] overall parity, [16:0] Hamming positions 1..17
// Notes:   Purely combinational
`timescale 1ns/1ns
module msac_parity (
	// Coded word in
	input  wire logic [17:0] code_i,
	// Decoded result
	output logic      [11:0] data_o,
	output logic             single_o,
	output logic             double_o
);
	logic [16:0] cw;
	logic [4:0]  syn;
	logic        ovr;
	always_comb begin
		cw  = code_i[16:0];
		syn = '0;
		for (int i = 1; i <= 17; i++) begin
			if (cw[i-1]) begin
				syn = syn ^ 5'(i);
			end
		end
		ovr = ^code_i;
		if (syn != '0 && ovr && syn <= 5'd17) begin
			cw[syn - 5'd1] = ~cw[syn - 5'd1];
		end
		single_o = ovr;
		double_o = (syn != '0) && !ovr;
		data_o   = {cw[16], cw[14:8], cw[6:4], cw[2]};
	end
endmodule

/* File: verilog/msac_top.sv */
// Purpose: Sample front end and limit comparator of a signal monitor
// Assumes: One clock at 4.9152 MHz; EEPROM read returns data in the same cycle as the strobe
// Notes:   Processor and host access through plain strobe ports
`timescale 1ns/1ns
module msac_top
	import msac_pkg::*;
#(
	parameter int unsigned NPARAM = msac_pkg::NUM_PARAMS
) (
	// Clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           arst_n_i,
	// Front end
	input  wire logic                           diff_freq_pulse_i,
	input  wire logic [msac_pkg::DATA_W-1:0]    adc_data_i,
	input  wire logic [msac_pkg::DATA_W-1:0]    ext_chan_data_i,
	input  wire logic [3:0]                     loop_detect_value_i,
	input  wire logic [msac_pkg::DATA_W-1:0]    ext_value_i,
	input  wire logic [msac_pkg::DATA_W-1:0]    test_value_i,
	output logic      [3:0]                     adc_chan_o,
	output logic      [2:0]                     ext_chan_o,
	output logic                                adc_convert_o,
	// Processor sample side
	input  wire logic                           sample_rd_i,
	output logic      [msac_pkg::ENTRY_W-1:0]   sample_data_o,
	output logic                                sample_available_o,
	// Processor parameter write
	input  wire logic                           param_wr_i,
	input  wire logic [4:0]                     param_num_i,
	input  wire logic [msac_pkg::DATA_W-1:0]    param_value_i,
	output logic                                param_busy_o,
	// EEPROM
	output logic      [msac_pkg::EE_ADDR_W-1:0] ee_addr_o,
	output logic                                ee_rd_o,
	output logic                                ee_wr_o,
	output logic      [msac_pkg::EE_DATA_W-1:0] ee_wdata_o,
	input  wire logic [msac_pkg::EE_DATA_W-1:0] ee_rdata_i,
	// Host
	input  wire logic                           host_access_level_n_i,
	input  wire logic                           host_ee_wr_i,
	input  wire logic                           host_ee_addr_rst_i,
	input  wire logic [msac_pkg::EE_DATA_W-1:0] host_ee_wdata_i,
	input  wire logic                           host_err_clr_i,
	output logic                                host_out_wr_o,
	output logic      [23:0]                    host_out_data_o,
	output logic                                host_irq_o,
	output logic                                host_parity_warn_o,
	output logic                                host_parity_err_o,
	output logic                                host_sample_err_o,
	output logic                                host_ee_wr_denied_o,
	output logic      [msac_pkg::EE_ADDR_W-1:0] host_ee_addr_o,
	input  wire logic                           host_irq_ack_i,
	// Station control alarm bus
	output logic      [4:0]                     sc_alarm_param_id_o,
	output logic                                sc_alarm_ready_n_o,
	output logic                                sc_alarm_flag_o,
	output logic                                sc_alarm_flag_inv_o,
	output logic                                sc_alarm_raw_o,
	// Terminator alarm bus
	output logic      [4:0]                     term_alarm_param_id_o,
	output logic                                term_alarm_ready_n_o,
	output logic                                term_alarm_flag_o,
	output logic                                term_alarm_flag_inv_o,
	output logic                                term_alarm_raw_o
);
	import msac_pkg::*;
	localparam int unsigned DW = $clog2(SLOT_DIV);

	logic [DW-1:0] div_q, div_d;
	logic [4:0]    slot_q, slot_d;
	logic [11:0]   df_cnt_q, df_cnt_d, df_lat_q, df_lat_d;
	logic          df_prev_q, conv_q, conv_d, slot_tick;
	logic          swr;
	logic [ENTRY_W-1:0] swdata;
	logic [DATA_W-1:0]  sval;
	always_comb begin
		slot_tick = (div_q == DW'(SLOT_DIV - 1));
		div_d  = slot_tick ? '0 : div_q + 1'b1;
		slot_d = slot_q;
		// Slots past the last channel stay idle to keep 640 Hz
		if (slot_tick) begin
			slot_d = slot_q + 1'b1;
		end
		conv_d = (div_q < DW'(CONV_PULSE_LEN));
		df_cnt_d = df_cnt_q + 12'(diff_freq_pulse_i && !df_prev_q);
		df_lat_d = df_lat_q;
		if (slot_tick && slot_q == CH_DIFF_FREQ) begin
			df_lat_d = df_cnt_q;
			df_cnt_d = 12'(diff_freq_pulse_i && !df_prev_q);
		end
		if (slot_q == CH_DIFF_FREQ) begin
			sval = df_lat_q;
		end else if (slot_q < CH_EXT_BASE) begin
			sval = adc_data_i;
		end else if (slot_q < CH_LOOP) begin
			sval = ext_chan_data_i;
		end else if (slot_q == CH_LOOP) begin
			sval = {8'h00, loop_detect_value_i};
		end else if (slot_q == CH_EXT_VAL) begin
			sval = ext_value_i;
		end else begin
			sval = test_value_i;
		end
		swr    = slot_tick && (slot_q <= CH_LAST);
		swdata = {slot_q, sval};
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q     <= '0;
			slot_q    <= '0;
			df_cnt_q  <= '0;
			df_lat_q  <= '0;
			df_prev_q <= 1'b0;
			conv_q    <= 1'b0;
		end else begin
			div_q     <= div_d;
			slot_q    <= slot_d;
			df_cnt_q  <= df_cnt_d;
			df_lat_q  <= df_lat_d;
			df_prev_q <= diff_freq_pulse_i;
			conv_q    <= conv_d;
		end
	end
	assign adc_chan_o    = 4'(slot_q - CH_ADC_BASE);
	assign ext_chan_o    = 3'(slot_q - CH_EXT_BASE);
	assign adc_convert_o = conv_q;

	logic sfifo_err;
	msac_sample_fifo #(
		.WIDTH (ENTRY_W),
		.DEPTH (SFIFO_DEPTH)
	) u_sfifo (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.wr_i      (swr),
		.wdata_i   (swdata),
		.rd_i      (sample_rd_i),
		.rdata_o   (sample_data_o),
		.avail_o   (sample_available_o),
		.err_clr_i (host_err_clr_i),
		.err_o     (sfifo_err)
	);

	// Comparator
	msac_seq_t   st_q, st_d;
	logic [4:0]  pnum_q, pnum_d, exp_id_q, exp_id_d;
	logic [11:0] pval_q, pval_d, dcnt_q [NPARAM], dcnt_d;
	logic [NPARAM-1:0] dal_q, dal_d;
	logic        raw_q, raw_d, pw_q, pw_d, pe_q, pe_d, seqerr_q, seqerr_d;
	logic        ee_rd_d, ee_wr_d, outwr_d, irq_d, denied_d, dal_now;
	logic [EE_ADDR_W-1:0] ee_addr_d, hadr_q, hadr_d;
	logic [23:0] odata_d;
	logic [11:0] eedat;
	logic        ee_single, ee_double, force_al;
	logic [5:0]  setcnt_q, setcnt_d;
	msac_parity u_par (
		.code_i   (ee_rdata_i),
		.data_o   (eedat),
		.single_o (ee_single),
		.double_o (ee_double)
	);
	always_comb begin
		st_d      = st_q;
		pnum_d    = pnum_q;
		pval_d    = pval_q;
		raw_d     = raw_q;
		pw_d      = pw_q;
		pe_d      = pe_q;
		dal_d     = dal_q;
		dcnt_d    = dcnt_q[pnum_q];
		ee_rd_d   = 1'b0;
		ee_addr_d = ee_addr_o;
		ee_wr_d   = 1'b0;
		outwr_d   = 1'b0;
		odata_d   = host_out_data_o;
		exp_id_d  = exp_id_q;
		seqerr_d  = seqerr_q;
		setcnt_d  = setcnt_q;
		irq_d     = host_irq_o && !host_irq_ack_i;
		hadr_d    = hadr_q;
		denied_d  = host_ee_wr_denied_o;
		dal_now   = dal_q[pnum_q];
		force_al  = pe_q;
		unique case (st_q)
			MSAC_IDLE: begin
				if (param_wr_i) begin
					pnum_d    = param_num_i;
					pval_d    = param_value_i;
					pw_d      = 1'b0;
					pe_d      = 1'b0;
					ee_rd_d   = 1'b1;
					ee_addr_d = {1'b0, param_num_i, EE_SEL_UPPER};
					st_d      = MSAC_UPPER;
				end else if (host_ee_wr_i) begin
					ee_wr_d   = !host_access_level_n_i;
					denied_d  = host_access_level_n_i;
					ee_addr_d = hadr_q;
					hadr_d    = hadr_q + EE_ADDR_W'(!host_access_level_n_i);
				end
			end
			MSAC_UPPER: begin
				raw_d     = (pval_q > eedat);
				pw_d      = ee_single;
				pe_d      = ee_double;
				ee_rd_d   = 1'b1;
				ee_addr_d = {1'b0, pnum_q, EE_SEL_LOWER};
				st_d      = MSAC_LOWER;
			end
			MSAC_LOWER: begin
				raw_d     = raw_q || (pval_q < eedat);
				pw_d      = pw_q || ee_single;
				pe_d      = pe_q || ee_double;
				ee_rd_d   = 1'b1;
				ee_addr_d = {1'b0, pnum_q, EE_SEL_DELAY};
				st_d      = MSAC_DELAY;
			end
			MSAC_DELAY: begin
				pw_d = pw_q || ee_single;
				pe_d = pe_q || ee_double;
				if (!raw_q) begin
					dcnt_d          = '0;
					dal_d[pnum_q]   = 1'b0;
				end else if (dcnt_q[pnum_q] >= eedat) begin
					dal_d[pnum_q]   = 1'b1;
				end else begin
					dcnt_d = dcnt_q[pnum_q] + 1'b1;
					dal_d[pnum_q]   = (dcnt_q[pnum_q] + 1'b1 >= eedat);
				end
				st_d = MSAC_EMIT;
			end
			MSAC_EMIT: begin
				force_al = pe_q;
				dal_now  = dal_q[pnum_q] || force_al;
				outwr_d  = 1'b1;
				seqerr_d = (pnum_q != exp_id_q);
				odata_d  = {pnum_q, dal_now, raw_q || force_al, pw_q, pe_q, 1'b0, seqerr_d, 1'b0, pval_q};
				exp_id_d = pnum_q + 1'b1;
				setcnt_d = setcnt_q + 1'b1;
				if (setcnt_q == 6'(NPARAM - 1)) begin
					setcnt_d = '0;
					irq_d    = 1'b1;
				end
				st_d = MSAC_IDLE;
			end
			default: st_d = MSAC_IDLE;
		endcase
		if (host_ee_addr_rst_i) begin
			hadr_d = '0;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q                  <= MSAC_IDLE;
			pnum_q                <= '0;
			pval_q                <= '0;
			raw_q                 <= 1'b0;
			pw_q                  <= 1'b0;
			pe_q                  <= 1'b0;
			dal_q                 <= '0;
			exp_id_q              <= '0;
			seqerr_q              <= 1'b0;
			setcnt_q              <= '0;
			hadr_q                <= '0;
			for (int i = 0; i < NPARAM; i++) begin
				dcnt_q[i] <= '0;
			end
			ee_rd_o               <= 1'b0;
			ee_wr_o               <= 1'b0;
			ee_addr_o             <= '0;
			ee_wdata_o            <= '0;
			host_out_wr_o         <= 1'b0;
			host_out_data_o       <= '0;
			host_irq_o            <= 1'b0;
			host_parity_warn_o    <= 1'b0;
			host_parity_err_o     <= 1'b0;
			host_sample_err_o     <= 1'b0;
			host_ee_wr_denied_o   <= 1'b0;
			host_ee_addr_o        <= '0;
			param_busy_o          <= 1'b0;
			sc_alarm_param_id_o   <= '0;
			sc_alarm_ready_n_o    <= 1'b1;
			sc_alarm_flag_o       <= 1'b0;
			sc_alarm_flag_inv_o   <= 1'b1;
			sc_alarm_raw_o        <= 1'b0;
			term_alarm_param_id_o <= '0;
			term_alarm_ready_n_o  <= 1'b1;
			term_alarm_flag_o     <= 1'b0;
			term_alarm_flag_inv_o <= 1'b1;
			term_alarm_raw_o      <= 1'b0;
		end else begin
			st_q                  <= st_d;
			pnum_q                <= pnum_d;
			pval_q                <= pval_d;
			raw_q                 <= raw_d;
			pw_q                  <= pw_d;
			pe_q                  <= pe_d;
			dal_q                 <= dal_d;
			exp_id_q              <= exp_id_d;
			seqerr_q              <= seqerr_d;
			setcnt_q              <= setcnt_d;
			hadr_q                <= hadr_d;
			dcnt_q[pnum_q]        <= dcnt_d;
			ee_rd_o               <= ee_rd_d;
			ee_wr_o               <= ee_wr_d;
			ee_addr_o             <= ee_addr_d;
			ee_wdata_o            <= host_ee_wdata_i;
			host_out_wr_o         <= outwr_d;
			host_out_data_o       <= odata_d;
			host_irq_o            <= irq_d;
			host_parity_warn_o    <= (st_q == MSAC_EMIT) ? pw_q : host_parity_warn_o;
			host_parity_err_o     <= (st_q == MSAC_EMIT) ? pe_q : host_parity_err_o;
			host_sample_err_o     <= sfifo_err;
			host_ee_wr_denied_o   <= denied_d;
			host_ee_addr_o        <= hadr_d;
			param_busy_o          <= (st_d != MSAC_IDLE);
			sc_alarm_ready_n_o    <= !outwr_d;
			term_alarm_ready_n_o  <= !outwr_d;
			if (outwr_d) begin
				sc_alarm_param_id_o   <= pnum_q;
				sc_alarm_flag_o       <= dal_now;
				sc_alarm_flag_inv_o   <= !dal_now;
				sc_alarm_raw_o        <= raw_q || force_al;
				term_alarm_param_id_o <= pnum_q;
				term_alarm_flag_o     <= dal_now;
				term_alarm_flag_inv_o <= !dal_now;
				term_alarm_raw_o      <= raw_q || force_al;
			end
		end
	end
endmodule

/* File: verif/msac_asserts.sv */
// Purpose: Port-level checks of the sample and alarm compare block
// Assumes: Walk timing as handed over, five cycles take to strobe
// Notes:   Bound to every msac_top instance
`timescale 1ns/1ns
module msac_checker
	import msac_pkg::*;
#(
	parameter int unsigned NPARAM = 32
) (
	// Clock and reset
	input	wire logic		clk_i,
	input	wire logic		arst_n_i,
	// Inputs watched
	input	wire logic		param_wr_i,
	input	wire logic [4:0]	param_num_i,
	input	wire logic		host_access_level_n_i,
	input	wire logic		host_ee_wr_i,
	// Outputs watched
	input	wire logic		param_busy_o,
	input	wire logic [7:0]	ee_addr_o,
	input	wire logic		ee_rd_o,
	input	wire logic		ee_wr_o,
	input	wire logic		adc_convert_o,
	input	wire logic		host_out_wr_o,
	input	wire logic		host_irq_o,
	// Alarm buses
	input	wire logic [4:0]	sc_alarm_param_id_o,
	input	wire logic		sc_alarm_ready_n_o,
	input	wire logic		sc_alarm_flag_o,
	input	wire logic		sc_alarm_flag_inv_o,
	input	wire logic		sc_alarm_raw_o,
	input	wire logic [4:0]	term_alarm_param_id_o,
	input	wire logic		term_alarm_ready_n_o,
	input	wire logic		term_alarm_flag_o,
	input	wire logic		term_alarm_flag_inv_o,
	input	wire logic		term_alarm_raw_o
);
	logic [5:0]	ocnt_q;
	logic [5:0]	ocnt_d;
	// Records since reset, modulo one set
	always_comb begin
		ocnt_d = ocnt_q;
		if (host_out_wr_o) begin
			ocnt_d = (ocnt_q == 6'(NPARAM - 1)) ? 6'h00 : ocnt_q + 6'h01;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ocnt_q <= 6'h00;
		end else begin
			ocnt_q <= ocnt_d;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_flag_inv:
	assert property (sc_alarm_flag_inv_o != sc_alarm_flag_o && term_alarm_flag_inv_o != term_alarm_flag_o)
		else $error("alarm complement not inverse of flag");
	a_bus_mirror:
	assert property ({sc_alarm_param_id_o, sc_alarm_ready_n_o, sc_alarm_flag_o, sc_alarm_raw_o} ==
		{term_alarm_param_id_o, term_alarm_ready_n_o, term_alarm_flag_o, term_alarm_raw_o})
		else $error("terminator bus differs from station bus");
	a_take_ready:
	assert property (param_wr_i && !param_busy_o |-> ##5 !sc_alarm_ready_n_o)
		else $error("no ready strobe five cycles after take");
	a_ready_pulse:
	assert property (!sc_alarm_ready_n_o |=> sc_alarm_ready_n_o)
		else $error("ready strobe longer than one cycle");
	a_out_record:
	assert property (!sc_alarm_ready_n_o |-> host_out_wr_o)
		else $error("no output record with alarm strobe");
	a_fetch_order:
	assert property (param_wr_i && !param_busy_o |=>
		ee_rd_o && ee_addr_o == {1'b0, $past(param_num_i), EE_SEL_UPPER}
		##1 ee_rd_o && ee_addr_o[1:0] == EE_SEL_LOWER ##1 ee_rd_o && ee_addr_o[1:0] == EE_SEL_DELAY)
		else $error("limit fetch order wrong");
	a_ee_wr_gate:
	assert property (ee_wr_o |-> $past(host_ee_wr_i) && !$past(host_access_level_n_i))
		else $error("memory write without granted access");
	a_conv_pulse:
	assert property ($rose(adc_convert_o) |=> adc_convert_o ##1 !adc_convert_o)
		else $error("convert pulse length wrong");
	a_irq_set:
	assert property ($rose(host_irq_o) |-> (ocnt_q == 6'h00 && !host_out_wr_o) ||
		(ocnt_q == 6'(NPARAM - 1) && host_out_wr_o))
		else $error("interrupt before a full set");
	c_alarm: cover property (!sc_alarm_ready_n_o && sc_alarm_flag_o);
	c_irq: cover property ($rose(host_irq_o));
	c_ee_wr: cover property (ee_wr_o);
endmodule

bind msac_top msac_checker #(.NPARAM(NPARAM)) chk_u (
	.clk_i, .arst_n_i, .param_wr_i, .param_num_i, .host_access_level_n_i, .host_ee_wr_i,
	.param_busy_o, .ee_addr_o, .ee_rd_o, .ee_wr_o, .adc_convert_o, .host_out_wr_o, .host_irq_o,
	.sc_alarm_param_id_o, .sc_alarm_ready_n_o, .sc_alarm_flag_o, .sc_alarm_flag_inv_o, .sc_alarm_raw_o,
	.term_alarm_param_id_o, .term_alarm_ready_n_o, .term_alarm_flag_o, .term_alarm_flag_inv_o,
	.term_alarm_raw_o
);

/* File: verif/msac_ee_model.sv */
// Purpose: Limit memory behind the comparator
// Assumes: Word valid while the read strobe stands
// Notes:   Bit flips injected on one address for parity tests
`timescale 1ns/1ns
module msac_ee_model (
	// Clock and reset
	input	wire logic		clk_i,
	input	wire logic		arst_n_i,
	// Memory port
	input	wire logic [7:0]	ee_addr_i,
	input	wire logic		ee_rd_i,
	input	wire logic		ee_wr_i,
	input	wire logic [17:0]	ee_wdata_i,
	output	logic [17:0]		ee_rdata_o,
	// Fault injection
	input	wire logic [7:0]	flip_addr_i,
	input	wire logic [17:0]	flip_mask_i
);
	logic [17:0]	mem [256];
	// check bits at powers of two
	function automatic logic [17:0] enc(input logic [11:0] d);
		logic [17:0]	c;
		int		k;
		c = 18'h00000;
		k = 0;
		for (int p = 1; p <= 17; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p-1] = d[k];
				k++;
			end
		end
		for (int i = 0; i < 5; i++) begin
			for (int p = 1; p <= 17; p++) begin
				if (((p >> i) & 1) == 1 && p != (1 << i)) begin
					c[(1<<i)-1] ^= c[p-1];
				end
			end
		end
		c[17] = ^c[16:0];
		return c;
	endfunction
	task automatic load(input logic [7:0] a, input logic [11:0] d);
		mem[a] = enc(d);
	endtask
	// word stands while read strobe is high
	// Idle bus shows the inverse so a stale word never looks valid
	assign ee_rdata_o = (ee_rd_i && arst_n_i) ?
		mem[ee_addr_i] ^ ((ee_addr_i == flip_addr_i) ? flip_mask_i : 18'h00000) : ~mem[ee_addr_i];
	always @(posedge clk_i) begin
		if (ee_wr_i) begin
			mem[ee_addr_i] <= ee_wdata_i;
		end
	end
endmodule

/* File: verif/testbench.sv */
// Purpose: Self-checking bench of the sample and alarm compare block
// Assumes: Limits preloaded, ids sent in set order
// Notes:   Diff count data not predicted, window undefined
`timescale 1ns/1ns
module testbench;
	import msac_pkg::*;
	logic		clk_i, arst_n_i, diff_freq_pulse_i, sample_rd_i, param_wr_i, host_access_level_n_i;
	logic		host_ee_wr_i, host_ee_addr_rst_i, host_err_clr_i, host_irq_ack_i;
	logic [11:0]	adc_data_i, ext_chan_data_i, ext_value_i, test_value_i, param_value_i;
	logic [3:0]	loop_detect_value_i, adc_chan_o;
	logic [4:0]	param_num_i, sc_alarm_param_id_o, term_alarm_param_id_o, a;
	logic [17:0]	host_ee_wdata_i, ee_wdata_o, ee_rdata_i, flip_mask;
	logic [7:0]	ee_addr_o, host_ee_addr_o, flip_addr, a0;
	logic [2:0]	ext_chan_o;
	logic [16:0]	sample_data_o;
	logic [23:0]	host_out_data_o, rec;
	logic		adc_convert_o, sample_available_o, param_busy_o, ee_rd_o, ee_wr_o, host_out_wr_o;
	logic		host_irq_o, host_parity_warn_o, host_parity_err_o, host_sample_err_o, host_ee_wr_denied_o;
	logic		sc_alarm_ready_n_o, sc_alarm_flag_o, sc_alarm_flag_inv_o, sc_alarm_raw_o;
	logic		term_alarm_ready_n_o, term_alarm_flag_o, term_alarm_flag_inv_o, term_alarm_raw_o;
	logic [15:0]	rng;
	logic [11:0]	dl_a [32];
	logic [23:0]	exp_q [$];
	int		mismatches, checked, cycles, run_a [32];
	msac_top dut_u (.clk_i, .arst_n_i, .diff_freq_pulse_i, .adc_data_i, .ext_chan_data_i, .loop_detect_value_i,
		.ext_value_i, .test_value_i, .adc_chan_o, .ext_chan_o, .adc_convert_o, .sample_rd_i, .sample_data_o,
		.sample_available_o, .param_wr_i, .param_num_i, .param_value_i, .param_busy_o, .ee_addr_o, .ee_rd_o,
		.ee_wr_o, .ee_wdata_o, .ee_rdata_i, .host_access_level_n_i, .host_ee_wr_i, .host_ee_addr_rst_i,
		.host_ee_wdata_i, .host_err_clr_i, .host_out_wr_o, .host_out_data_o, .host_irq_o, .host_parity_warn_o,
		.host_parity_err_o, .host_sample_err_o, .host_ee_wr_denied_o, .host_ee_addr_o, .host_irq_ack_i,
		.sc_alarm_param_id_o, .sc_alarm_ready_n_o, .sc_alarm_flag_o, .sc_alarm_flag_inv_o, .sc_alarm_raw_o,
		.term_alarm_param_id_o, .term_alarm_ready_n_o, .term_alarm_flag_o, .term_alarm_flag_inv_o,
		.term_alarm_raw_o);
	msac_ee_model ee_u (.clk_i, .arst_n_i, .ee_addr_i(ee_addr_o), .ee_rd_i(ee_rd_o), .ee_wr_i(ee_wr_o),
		.ee_wdata_i(ee_wdata_o), .ee_rdata_o(ee_rdata_i), .flip_addr_i(flip_addr), .flip_mask_i(flip_mask));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [11:0] slot_val(input logic [4:0] c);
		if (c == CH_TEST) return test_value_i;
		if (c == CH_EXT_VAL) return ext_value_i;
		if (c == CH_LOOP) return {8'h00, loop_detect_value_i};
		if (c >= CH_EXT_BASE) return ext_chan_data_i;
		return adc_data_i;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (e !== g) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask
	// Limits 100..800, delays zero except id 5
	task automatic send(input logic [4:0] id, input logic [11:0] v, input logic [1:0] err);
		logic raw;
		raw = err[0] | (v > 12'h800) | (v < 12'h100);
		run_a[id] = raw ? run_a[id] + 1 : 0;
		exp_q.push_back({id, err[0] | (raw && run_a[id] >= dl_a[id]), raw, err, 3'h0, v});
		chk("idle before write", 1'b0, param_busy_o);
		param_num_i = id;
		param_value_i = v;
		pulse(param_wr_i);
		repeat (5) @(negedge clk_i);
	endtask
	task automatic run_set(input string nm, input logic [4:0] fid, input logic [17:0] fm,
		input logic [1:0] err, input logic [11:0] v5);
		flip_addr = {1'b0, fid, EE_SEL_UPPER};
		flip_mask = fm;
		for (int i = 0; i < 32; i++) begin
			rng = lfsr(rng);
			send(5'(i), (i == 5) ? v5 : rng[11:0], (i == fid) ? err : 2'b00);
			if (i == 30) chk("irq before set end", 1'b0, host_irq_o);
		end
		repeat (3) @(negedge clk_i);
		chk("irq after set", 1'b1, host_irq_o);
		pulse(host_irq_ack_i);
		chk("irq acked", 1'b0, host_irq_o);
		$display("test %s done", nm);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	always @(negedge clk_i) diff_freq_pulse_i <= cycles[2];
	always @(negedge clk_i) begin
		if (arst_n_i === 1'b1 && sc_alarm_ready_n_o === 1'b0) begin
			rec = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hxxxxxx;
			chk("out strobe", 1'b1, host_out_wr_o);
			chk("host record", rec, host_out_data_o);
			chk("parity flags", rec[16:15], {host_parity_warn_o, host_parity_err_o});
			chk("sc bus", {rec[23:18], ~rec[18], rec[17]}, {sc_alarm_param_id_o, sc_alarm_flag_o,
				sc_alarm_flag_inv_o, sc_alarm_raw_o});
			chk("term bus", {rec[23:18], ~rec[18], rec[17]}, {term_alarm_param_id_o, term_alarm_flag_o,
				term_alarm_flag_inv_o, term_alarm_raw_o});
		end
	end
	initial begin
		{arst_n_i, sample_rd_i, param_wr_i, host_ee_wr_i, host_ee_addr_rst_i} = 5'h00;
		{host_err_clr_i, host_irq_ack_i, host_access_level_n_i, param_num_i, param_value_i} = 20'h20000;
		{host_ee_wdata_i, flip_addr, flip_mask} = 44'h00000000000;
		rng = 16'h5cac;
		{adc_data_i, ext_chan_data_i, ext_value_i, test_value_i, loop_detect_value_i} = 52'({4{rng}});
		for (int i = 0; i < 32; i++) begin
			dl_a[i] = (i == 5) ? 12'h002 : 12'h000;
			ee_u.load({1'b0, 5'(i), EE_SEL_UPPER}, 12'h800);
			ee_u.load({1'b0, 5'(i), EE_SEL_LOWER}, 12'h100);
			ee_u.load({1'b0, 5'(i), EE_SEL_DELAY}, dl_a[i]);
			ee_u.load({1'b0, 5'(i), EE_SEL_WARN}, 12'h700);
		end
		repeat (10) @(negedge clk_i);
		arst_n_i = 1'b1;
		@(negedge clk_i);
		chk("reset bus", 3'b110, {sc_alarm_ready_n_o, sc_alarm_flag_inv_o, host_irq_o});
		run_set("limits", 5'h1f, 18'h00000, 2'b00, 12'h900);
		run_set("single flip", 5'h03, 18'h00010, 2'b10, 12'h900);
		run_set("double flip", 5'h09, 18'h00030, 2'b01, 12'h900);
		run_set("back in limits", 5'h1f, 18'h00000, 2'b00, 12'h400);
		chk("records left", 0, exp_q.size());
		for (int n = 0; n < 4000 && host_sample_err_o !== 1'b1; n++) @(negedge clk_i);
		chk("overflow flag", 1'b1, host_sample_err_o);
		a = sample_data_o[16:12];
		for (int i = 0; i < 7; i++) begin
			chk("available", 1'b1, sample_available_o);
			chk("slot addr", a, sample_data_o[16:12]);
			if (a != CH_DIFF_FREQ) chk("slot data", slot_val(a), sample_data_o[11:0]);
			a = (a == CH_LAST) ? 5'h00 : a + 5'h01;
			pulse(sample_rd_i);
		end
		chk("seven deep", 1'b0, sample_available_o);
		pulse(host_err_clr_i);
		@(negedge clk_i);
		chk("flag cleared", 1'b0, host_sample_err_o);
		$display("test samples done");
		pulse(host_ee_addr_rst_i);
		a0 = host_ee_addr_o;
		host_ee_wdata_i = 18'h2a5c3;
		pulse(host_ee_wr_i);
		repeat (2) @(negedge clk_i);
		chk("write denied", 1'b1, host_ee_wr_denied_o);
		chk("addr held", a0, host_ee_addr_o);
		host_access_level_n_i = 1'b0;
		pulse(host_ee_wr_i);
		chk("write strobe", 1'b1, ee_wr_o);
		chk("write word", {a0, host_ee_wdata_i}, {ee_addr_o, ee_wdata_o});
		@(negedge clk_i);
		chk("addr step", a0 + 8'h01, host_ee_addr_o);
		$display("test memory write done");
		give_verdict();
	end
endmodule
